// ### selective_bus_monitor_store.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module selective_bus_monitor_store
  import monitor_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Decoded bus words
  input  wire rx_word_s    rx_word,
  // Synchronize-with-data from terminal logic
  input  wire logic        sync_valid,
  input  wire logic [15:0] sync_data,
  // Receiver sampling and decoder clock choice
  input  wire logic [3:0]  rx_lines,
  output logic      [3:0]  samp_rise,
  output logic      [3:0]  samp_fall,
  output logic      [1:0]  dec_clk_sel,
  // Shared RAM
  output mem_req_s         mem,
  input  wire logic [15:0] mem_rdata,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    mon_state_e        st;
    logic [CFG_W-1:0]  cfg;
    logic [STK_W-1:0]  stk;
    logic [1:0]        clksel;
    logic [5:0]        tt_cfg;
    logic [INT_W-1:0]  imask;
    logic [INT_W-1:0]  istat;
    logic [ISQ_AW-1:0] ridx;
    logic [31:0]       prdata;
    logic [15:0]       cmd;
    logic [15:0]       cptr;
    logic [15:0]       dptr;
    logic [15:0]       ent_ptr;
    logic [15:0]       dstart;
    logic [5:0]        rem;
    logic              first;
    logic              err;
    logic              rtrt;
    logic              bus_b;
    logic [GAP_W-1:0]  gap;
    logic [1:0]        idx;
    logic              irq;
    mem_req_s          mem;
    logic [3:0]        rx_s1;
    logic [3:0]        rx_s2;
  } mon_s;

  mon_s              q;
  mon_s              d;
  logic [3:0]        fall_s1;
  logic [3:0]        fall_s2;
  logic [INT_W-1:0]  ev;
  logic [INT_W-1:0]  clr;
  logic [INT_W-1:0]  set;
  logic [15:0]       cmsk;
  logic [15:0]       dmsk;
  logic [15:0]       np;
  logic [15:0]       bsw;
  logic              apb_setup;
  logic              apb_acc;
  logic              tt_wr;
  logic              tt_step;
  logic              isq_we;
  logic [15:0]       isq_wd;
  logic [15:0]       tt_count;
  logic              tt_roll;
  logic [15:0]       isq_rd;
  logic [ISQ_AW-1:0] isq_widx;
  logic              isq_wrap;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] cmd_mask(input logic [1:0] sel);
    return 16'hffff >> (4'd8 - {1'b0, sel, 1'b0});
  endfunction

  function automatic logic [15:0] data_mask(input logic [2:0] sel);
    return 16'hffff >> (3'd7 - sel);
  endfunction

  function automatic logic [15:0] stk_next(input logic [15:0] p, input logic [15:0] step,
                                           input logic [15:0] msk);
    return (p & ~msk) | ((p + step) & msk);
  endfunction

  function automatic logic half_hit(input logic [15:0] p, input logic [15:0] msk);
    return (p & msk) == ((msk >> 1) + 16'h0001);
  endfunction

  function automatic logic [5:0] data_count(input logic [15:0] c);
    if (c[9:5] == 5'h00 || c[9:5] == 5'h1f) begin
      return c[4] ? 6'd1 : 6'd0;
    end
    return (c[4:0] == 5'h00) ? 6'd32 : {1'b0, c[4:0]};
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    return a[1:0] == 2'b00 && a <= REG_DATA_PTR;
  endfunction

  // ==========================================================================
  // Submodules
  time_tag_counter u_tt (
    .pclk       (pclk),
    .presetn    (presetn),
    .res_sel    (q.tt_cfg[2:0]),
    .step_mode  (q.tt_cfg[TT_STEP_MODE]),
    .sync_en    (q.tt_cfg[TT_SYNC_EN]),
    .sync_lsb0  (q.tt_cfg[TT_SYNC_LSB0]),
    .step_pulse (tt_step),
    .wr_en      (tt_wr),
    .wr_data    (pwdata[15:0]),
    .sync_valid (sync_valid),
    .sync_data  (sync_data),
    .count      (tt_count),
    .rollover   (tt_roll)
  );

  isq_store u_isq (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (isq_we),
    .wr_data (isq_wd),
    .rd_idx  (q.ridx),
    .rd_data (isq_rd),
    .wr_idx  (isq_widx),
    .wrap    (isq_wrap)
  );

  // ==========================================================================
  // Falling-edge receiver samples
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_s1 <= '0;
      fall_s2 <= '0;
    end else begin
      fall_s1 <= rx_lines;
      fall_s2 <= fall_s1;
    end
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    d         = q;
    ev        = '0;
    clr       = '0;
    tt_wr     = 1'b0;
    tt_step   = 1'b0;
    isq_we    = 1'b0;
    isq_wd    = '0;
    np        = '0;
    apb_setup = psel && !penable;
    apb_acc   = psel && penable;
    cmsk      = cmd_mask(q.stk[1:0]);
    dmsk      = data_mask(q.stk[4:2]);
    bsw       = '0;
    bsw[BSW_EOM]   = 1'b1;
    bsw[BSW_ERR]   = q.err;
    bsw[BSW_RTRT]  = q.rtrt;
    bsw[BSW_BUS_B] = q.bus_b;
    d.mem     = '0;
    d.rx_s1   = rx_lines;
    d.rx_s2   = q.rx_s1;

    // Read data is fetched in the setup phase
    if (apb_setup) begin
      case (paddr)
        REG_CFG:      d.prdata = 32'(q.cfg);
        REG_STACK:    d.prdata = 32'(q.stk);
        REG_CLKSEL:   d.prdata = 32'(q.clksel);
        REG_TT_CFG:   d.prdata = 32'(q.tt_cfg);
        REG_TT:       d.prdata = 32'(tt_count);
        REG_IMASK:    d.prdata = 32'(q.imask);
        REG_ISTAT:    d.prdata = 32'(q.istat);
        REG_ISQ_PTR:  d.prdata = 32'(isq_widx);
        REG_ISQ_RIDX: d.prdata = 32'(q.ridx);
        REG_ISQ_DATA: d.prdata = 32'(isq_rd);
        REG_CMD_PTR:  d.prdata = 32'(q.cptr);
        REG_DATA_PTR: d.prdata = 32'(q.dptr);
        default:      d.prdata = '0;
      endcase
    end
    if (apb_acc && pwrite) begin
      case (paddr)
        REG_CFG:      d.cfg    = pwdata[CFG_W-1:0];
        REG_STACK:    d.stk    = pwdata[STK_W-1:0];
        REG_CLKSEL:   d.clksel = pwdata[CLKSEL_W-1:0];
        REG_TT_CFG:   d.tt_cfg = pwdata[TT_CFG_W-1:0];
        REG_TT:       tt_wr    = 1'b1;
        REG_TT_STEP:  tt_step  = 1'b1;
        REG_IMASK:    d.imask  = pwdata[INT_W-1:0];
        REG_ICLR:     clr      = pwdata[INT_W-1:0];
        REG_ISQ_RIDX: d.ridx   = pwdata[ISQ_AW-1:0];
        default:      ;
      endcase
    end
    if (apb_acc && !pwrite && paddr == REG_ISTAT && q.cfg[CFG_AUTO_CLR]) begin
      clr = '1;
    end

    // Message monitor
    case (q.st)
      S_IDLE: begin
        if (q.cfg[CFG_MON_EN] && rx_word.valid && rx_word.csync && !rx_word.err) begin
          d.cmd   = rx_word.data;
          d.bus_b = rx_word.bus_b;
          d.st    = S_LK_RD;
        end
      end
      S_LK_RD: begin
        d.mem.req  = 1'b1;
        d.mem.addr = LUT_BASE_ADDR | {9'h000, q.cmd[15:9]};
        d.st       = S_LK_W;
      end
      S_LK_W: d.st = S_LK_CHK;
      S_LK_CHK: begin
        d.st = mem_rdata[q.cmd[8:5]] ? S_CP_RD : S_IDLE;
      end
      S_CP_RD: begin
        d.mem.req  = 1'b1;
        d.mem.addr = q.cfg[CFG_AREA_B] ? CMD_PTR_B_ADDR : CMD_PTR_A_ADDR;
        d.st       = S_DP_RD;
      end
      S_DP_RD: begin
        d.mem.req  = 1'b1;
        d.mem.addr = q.cfg[CFG_AREA_B] ? DATA_PTR_B_ADDR : DATA_PTR_A_ADDR;
        d.st       = S_CP_GET;
      end
      S_CP_GET: begin
        d.cptr    = mem_rdata;
        d.ent_ptr = mem_rdata;
        d.st      = S_DP_GET;
      end
      S_DP_GET: begin
        d.dptr   = mem_rdata;
        d.dstart = mem_rdata;
        d.rem    = data_count(q.cmd) +
                   ((q.cmd[CMD_TR] || q.cmd[15:11] != RT_BCST) ? 6'd1 : 6'd0);
        d.first  = 1'b1;
        d.err    = 1'b0;
        d.rtrt   = 1'b0;
        d.gap    = '0;
        d.idx    = '0;
        d.st     = (d.rem == 6'd0) ? S_ENT : S_COLLECT;
      end
      S_COLLECT: begin
        if (rx_word.valid) begin
          d.gap = '0;
          if (rx_word.err) begin
            d.err = 1'b1;
            d.st  = S_ENT;
          end else begin
            d.mem.req   = 1'b1;
            d.mem.we    = 1'b1;
            d.mem.addr  = q.dptr;
            d.mem.wdata = rx_word.data;
            np          = stk_next(q.dptr, 16'h0001, dmsk);
            d.dptr      = np;
            ev[INT_DATA_HALF] = half_hit(np, dmsk);
            ev[INT_DATA_WRAP] = (np & dmsk) == 16'h0000;
            if (q.first && !q.cmd[CMD_TR] && rx_word.csync && rx_word.data[CMD_TR]) begin
              d.rtrt = 1'b1;
              d.rem  = q.rem + 6'd1;
            end else begin
              d.rem = q.rem - 6'd1;
            end
            d.first = 1'b0;
            if (d.rem == 6'd0) begin
              d.st = S_ENT;
            end
          end
        end else if (q.gap == GAP_LAST) begin
          d.err = 1'b1;
          d.st  = S_ENT;
        end else begin
          d.gap = q.gap + 1'b1;
        end
      end
      S_ENT: begin
        d.mem.req  = 1'b1;
        d.mem.we   = 1'b1;
        d.mem.addr = q.cptr + 16'(q.idx);
        case (q.idx)
          2'd0:    d.mem.wdata = bsw;
          2'd1:    d.mem.wdata = tt_count;
          2'd2:    d.mem.wdata = q.dstart;
          default: d.mem.wdata = q.cmd;
        endcase
        d.idx = q.idx + 2'd1;
        if (q.idx == 2'd3) begin
          np     = stk_next(q.cptr, ENTRY_WORDS, cmsk);
          d.cptr = np;
          ev[INT_CMD_HALF] = half_hit(np, cmsk);
          ev[INT_CMD_WRAP] = (np & cmsk) == 16'h0000;
          d.st   = S_WB_CP;
        end
      end
      S_WB_CP: begin
        d.mem.req   = 1'b1;
        d.mem.we    = 1'b1;
        d.mem.addr  = q.cfg[CFG_AREA_B] ? CMD_PTR_B_ADDR : CMD_PTR_A_ADDR;
        d.mem.wdata = q.cptr;
        d.st        = S_WB_DP;
      end
      S_WB_DP: begin
        d.mem.req   = 1'b1;
        d.mem.we    = 1'b1;
        d.mem.addr  = q.cfg[CFG_AREA_B] ? DATA_PTR_B_ADDR : DATA_PTR_A_ADDR;
        d.mem.wdata = q.dptr;
        ev[INT_EOM] = 1'b1;
        d.st        = S_IDLE;
        if (q.cfg[CFG_ISQ_EN] && (q.err ? q.cfg[CFG_ISQ_INVALID] : q.cfg[CFG_ISQ_VALID])) begin
          isq_we = 1'b1;
          isq_wd = bsw;
          d.st   = S_ISQ;
        end
      end
      S_ISQ: begin
        isq_we = 1'b1;
        isq_wd = q.ent_ptr;
        d.st   = S_IDLE;
      end
      default: d.st = S_IDLE;
    endcase

    // Interrupt status: a new event wins over a clear in the same cycle
    ev[INT_TT_WRAP]  = tt_roll;
    ev[INT_ISQ_WRAP] = isq_wrap;
    set     = q.cfg[CFG_ENH_INT] ? ev : (ev & q.imask);
    d.istat = (q.istat & ~clr) | set;
    d.irq   = |(d.istat & d.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.st     <= S_IDLE;
      q.cfg    <= CFG_RST;
      q.stk    <= STK_RST;
      q.clksel <= CLKSEL_RST;
      q.tt_cfg <= TT_CFG_RST;
      q.imask  <= IMASK_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata      = q.prdata;
  assign pready      = 1'b1;
  assign pslverr     = apb_acc && !reg_hit(paddr);
  assign samp_rise   = q.rx_s2;
  assign samp_fall   = fall_s2;
  assign dec_clk_sel = q.clksel;
  assign mem         = q.mem;
  assign irq         = q.irq;

endmodule

// ### monitor_pkg.sv
package monitor_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int          CLK_MHZ      = 25;
  localparam int          TT_BASE_US   = 2;
  localparam int          TT_BASE_CYC  = TT_BASE_US * CLK_MHZ;
  localparam int          TT_RES_MAX   = 5;
  localparam int          GAP_US       = 16;
  localparam int          GAP_CYC      = GAP_US * CLK_MHZ;
  localparam int          GAP_W        = 9;
  localparam logic [8:0]  GAP_LAST     = 9'(GAP_CYC - 1);

  // ==========================================================================
  // Fixed shared-RAM locations
  localparam logic [15:0] CMD_PTR_A_ADDR  = 16'h0102;
  localparam logic [15:0] DATA_PTR_A_ADDR = 16'h0103;
  localparam logic [15:0] CMD_PTR_B_ADDR  = 16'h0106;
  localparam logic [15:0] DATA_PTR_B_ADDR = 16'h0107;
  localparam logic [15:0] LUT_BASE_ADDR   = 16'h0280;
  localparam logic [15:0] ENTRY_WORDS     = 16'h0004;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] REG_CFG       = 12'h000;
  localparam logic [11:0] REG_STACK     = 12'h004;
  localparam logic [11:0] REG_CLKSEL    = 12'h008;
  localparam logic [11:0] REG_TT_CFG    = 12'h00c;
  localparam logic [11:0] REG_TT        = 12'h010;
  localparam logic [11:0] REG_TT_STEP   = 12'h014;
  localparam logic [11:0] REG_IMASK     = 12'h018;
  localparam logic [11:0] REG_ISTAT     = 12'h01c;
  localparam logic [11:0] REG_ICLR      = 12'h020;
  localparam logic [11:0] REG_ISQ_PTR   = 12'h024;
  localparam logic [11:0] REG_ISQ_RIDX  = 12'h028;
  localparam logic [11:0] REG_ISQ_DATA  = 12'h02c;
  localparam logic [11:0] REG_CMD_PTR   = 12'h030;
  localparam logic [11:0] REG_DATA_PTR  = 12'h034;

  // ==========================================================================
  // Register fields and reset values
  localparam int          CFG_W           = 7;
  localparam int          CFG_MON_EN      = 0;
  localparam int          CFG_AREA_B      = 1;
  localparam int          CFG_ENH_INT     = 2;
  localparam int          CFG_AUTO_CLR    = 3;
  localparam int          CFG_ISQ_VALID   = 4;
  localparam int          CFG_ISQ_INVALID = 5;
  localparam int          CFG_ISQ_EN      = 6;
  localparam logic [6:0]  CFG_RST         = 7'h00;
  localparam int          STK_W           = 5;
  localparam logic [4:0]  STK_RST         = 5'h00;
  localparam int          CLKSEL_W        = 2;
  localparam logic [1:0]  CLKSEL_RST      = 2'h0;
  localparam int          TT_CFG_W        = 6;
  localparam int          TT_STEP_MODE    = 3;
  localparam int          TT_SYNC_EN      = 4;
  localparam int          TT_SYNC_LSB0    = 5;
  localparam logic [5:0]  TT_CFG_RST      = 6'h00;
  localparam int          INT_W           = 7;
  localparam int          INT_EOM         = 0;
  localparam int          INT_CMD_HALF    = 1;
  localparam int          INT_CMD_WRAP    = 2;
  localparam int          INT_DATA_HALF   = 3;
  localparam int          INT_DATA_WRAP   = 4;
  localparam int          INT_TT_WRAP     = 5;
  localparam int          INT_ISQ_WRAP    = 6;
  localparam logic [6:0]  IMASK_RST       = 7'h00;

  // Block status word and command word fields
  localparam int          BSW_ERR      = 0;
  localparam int          BSW_RTRT     = 1;
  localparam int          BSW_BUS_B    = 2;
  localparam int          BSW_EOM      = 15;
  localparam int          CMD_TR       = 10;
  localparam logic [4:0]  RT_BCST      = 5'h1f;

  // Interrupt status queue
  localparam int          ISQ_DEPTH    = 64;
  localparam int          ISQ_AW       = 6;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    S_IDLE, S_LK_RD, S_LK_W, S_LK_CHK, S_CP_RD, S_DP_RD, S_CP_GET, S_DP_GET,
    S_COLLECT, S_ENT, S_WB_CP, S_WB_DP, S_ISQ
  } mon_state_e;

  typedef struct packed {
    logic        valid;
    logic        csync;
    logic        err;
    logic        bus_b;
    logic [15:0] data;
  } rx_word_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_s;

endpackage

// ### time_tag_counter.sv
`timescale 1ns/100ps
module time_tag_counter
  import monitor_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration
  input  wire logic [2:0]  res_sel,
  input  wire logic        step_mode,
  input  wire logic        sync_en,
  input  wire logic        sync_lsb0,
  // Updates
  input  wire logic        step_pulse,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        sync_valid,
  input  wire logic [15:0] sync_data,
  // Counter
  output logic      [15:0] count,
  output logic             rollover
);

  typedef struct packed {
    logic [15:0] count;
    logic [10:0] div;
    logic        roll;
  } tt_s;

  tt_s         q;
  tt_s         d;
  logic [2:0]  res;
  logic [10:0] limit;
  logic        tick;

  // ==========================================================================
  // Tick divider and counter
  always_comb begin
    res   = (res_sel > 3'(TT_RES_MAX)) ? 3'(TT_RES_MAX) : res_sel;
    limit = 11'((TT_BASE_CYC << res) - 1);
    d      = q;
    d.roll = 1'b0;
    tick   = 1'b0;
    if (step_mode) begin
      d.div = '0;
      tick  = step_pulse;
    end else if (q.div == limit) begin
      d.div = '0;
      tick  = 1'b1;
    end else begin
      d.div = q.div + 11'd1;
    end
    if (wr_en) begin
      d.count = wr_data;
    end else if (sync_valid && sync_en && (!sync_lsb0 || !sync_data[0])) begin
      d.count = sync_data;
    end else if (tick) begin
      d.count = q.count + 16'd1;
      d.roll  = (q.count == 16'hffff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count    = q.count;
  assign rollover = q.roll;

endmodule

// ### isq_store.sv
`timescale 1ns/100ps
module isq_store
  import monitor_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Write side
  input  wire logic              wr_en,
  input  wire logic [15:0]       wr_data,
  // Read side
  input  wire logic [ISQ_AW-1:0] rd_idx,
  output logic      [15:0]       rd_data,
  output logic      [ISQ_AW-1:0] wr_idx,
  output logic                   wrap
);

  typedef struct packed {
    logic [ISQ_DEPTH-1:0][15:0] mem;
    logic [ISQ_AW-1:0]          widx;
    logic [15:0]                rd;
    logic                       wrap;
  } isq_s;

  isq_s q;
  isq_s d;

  // ==========================================================================
  // Circular queue, oldest entries overwritten once full
  always_comb begin
    d      = q;
    d.wrap = 1'b0;
    d.rd   = q.mem[rd_idx];
    if (wr_en) begin
      d.mem[q.widx] = wr_data;
      d.widx        = q.widx + 1'b1;
      d.wrap        = (q.widx == '1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd;
  assign wr_idx  = q.widx;
  assign wrap    = q.wrap;

endmodule

// ### store_monitor.sv
`timescale 1ns/100ps
module store_monitor
  import monitor_pkg::*;
(
  // Watched ports
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire rx_word_s   rx_word,
  input wire logic [3:0] rx_lines,
  input wire logic [3:0] samp_rise,
  input wire logic [3:0] samp_fall,
  input wire mem_req_s   mem,
  input wire logic       irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = mem.req && !mem.we;
  wire lut = rd && mem.addr[15:7] == 9'h005;
  wire pa = mem.addr == CMD_PTR_A_ADDR || mem.addr == CMD_PTR_B_ADDR;
  chk_lut_addr: assert property (lut |-> mem.addr[6:0] == $past(rx_word.data[15:9], 2))
    else $error("lookup address wrong");
  chk_lut_kept: assert property (mem.req && mem.we |-> mem.addr[15:7] != 9'h005)
    else $error("lookup table written");
  chk_ptr_pair: assert property (rd && pa |=> rd && mem.addr == $past(mem.addr) + 16'h1)
    else $error("data pointer read missing");
  chk_ptr_lookup: assert property (rd && pa |-> $past(lut, 3))
    else $error("pointer read without lookup");
  chk_ptr_back: assert property (mem.req && mem.we && pa |=> mem.we && mem.addr[0])
    else $error("pointer write back order");
  chk_irq_held: assert property ($fell(irq) |-> $past(psel && penable))
    else $error("irq dropped by itself");
  chk_rise_samp: assert property (samp_rise == $past(rx_lines, 2))
    else $error("rising sample wrong");
  chk_fall_samp: assert property (@(negedge pclk) disable iff (!presetn)
    samp_fall == $past(rx_lines, 2)) else $error("falling sample wrong");
endmodule
bind selective_bus_monitor_store store_monitor store_monitor_i (.pclk, .presetn, .psel,
  .penable, .rx_word, .rx_lines, .samp_rise, .samp_fall, .mem, .irq);

// ### ram_model.sv
`timescale 1ns/100ps
module ram_model
  import monitor_pkg::*;
(
  // Shared RAM port
  input  wire logic        pclk,
  input  wire mem_req_s    mem,
  output logic      [15:0] mem_rdata
);
  logic [15:0] ram [0:4095];
  // Idle port shows the inverse of the last word
  always @(posedge pclk) begin
    if (mem.req && mem.we) ram[mem.addr[11:0]] <= mem.wdata;
    mem_rdata <= (mem.req && !mem.we) ? ram[mem.addr[11:0]] : ~mem_rdata;
  end
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench
  import monitor_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, sync_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  rx_lines, samp_rise, samp_fall;
  logic [1:0]  dec_clk_sel;
  logic [15:0] mem_rdata, sync_data;
  rx_word_s    rx_word;
  mem_req_s    mem;
  int          fail_count, samples_checked;
  selective_bus_monitor_store selective_bus_monitor_store_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_word, .sync_valid,
    .sync_data, .rx_lines, .samp_rise, .samp_fall, .dec_clk_sel, .mem, .mem_rdata,
    .irq);
  ram_model ram_model_i (.pclk, .mem, .mem_rdata);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (presetn) rx_lines <= rx_lines + 4'h1;
  function automatic logic [15:0] m(input logic [11:0] a);
    return ram_model_i.ram[a];
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task word(input logic c, input logic [15:0] d);
    @(posedge pclk);
    rx_word <= '{1'b1, c, 1'b0, 1'b0, d};
    @(posedge pclk);
    rx_word.valid <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  task syn(input logic [15:0] d);
    @(posedge pclk);
    sync_valid <= 1'b1;
    sync_data <= d;
    @(posedge pclk);
    sync_valid <= 1'b0;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", n, x, g);
      fail_count++;
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_lines, presetn, sync_valid, sync_data} = '0;
    rx_word = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, REG_CLKSEL, i);
      chk("clock select", i, dec_clk_sel);
    end
    apb(1'b0, 12'hffc, 0);
    chk("unmapped error", 1, e);
    apb(1'b1, REG_TT_CFG, 8);
    apb(1'b1, REG_TT, 32'h1234);
    apb(1'b1, REG_TT_STEP, 0);
    apb(1'b0, REG_TT, 0);
    chk("time tag", 32'h1235, r);
    $display("register test done");
    for (int i = 0; i < 128; i++) ram_model_i.ram[12'h280 + i] = 16'h0000;
    ram_model_i.ram[12'h294] = 16'h0002;
    ram_model_i.ram[12'h102] = 16'h0400;
    ram_model_i.ram[12'h103] = 16'h0800;
    apb(1'b1, REG_IMASK, 1);
    apb(1'b1, REG_CFG, 1);
    word(1'b1, 16'h2822);
    word(1'b0, 16'h1111);
    word(1'b0, 16'h2222);
    word(1'b1, 16'h2800);
    chk("data words", 32'h11112222, {m(12'h800), m(12'h801)});
    chk("status word", 32'h2800, m(12'h802));
    chk("tag and start", 32'h12350800, {m(12'h401), m(12'h402)});
    chk("command word", 32'h2822, m(12'h403));
    chk("stack pointers", 32'h04040803, {m(12'h102), m(12'h103)});
    chk("irq", 1, irq);
    apb(1'b0, REG_ISTAT, 0);
    chk("status reg", 1, r);
    apb(1'b1, REG_ICLR, 1);
    repeat (2) @(negedge pclk);
    chk("irq clear", 0, irq);
    $display("message test done");
    word(1'b1, 16'h2842);
    word(1'b0, 16'h3333);
    word(1'b1, 16'h2800);
    chk("pointer kept", 32'h0404, m(12'h102));
    $display("discard test done");
    ram_model_i.ram[12'h102] = 16'h047c;
    apb(1'b1, REG_CFG, 32'h55);
    word(1'b1, 16'h2822);
    word(1'b0, 16'h4444);
    word(1'b0, 16'h5555);
    word(1'b1, 16'h2800);
    chk("second data", 32'h44445555, {m(12'h803), m(12'h804)});
    apb(1'b0, REG_ISTAT, 0);
    chk("enhanced status", 3, r);
    apb(1'b0, REG_ISQ_PTR, 0);
    chk("queue pointer", 2, r);
    apb(1'b1, REG_ISQ_RIDX, 1);
    apb(1'b0, REG_ISQ_DATA, 0);
    chk("queue entry", 32'h047c, r);
    apb(1'b1, REG_ICLR, 32'h7f);
    $display("queue test done");
    apb(1'b1, REG_TT_CFG, 32'h38);
    syn(16'h0a00);
    syn(16'h0101);
    apb(1'b0, REG_TT, 0);
    chk("sync load", 32'h0a00, r);
    apb(1'b1, REG_TT, 32'hffff);
    apb(1'b1, REG_TT_STEP, 0);
    apb(1'b0, REG_ISTAT, 0);
    chk("tag wrap", 32'h20, r);
    $display("time tag test done");
    close_out;
  end
  initial begin
    #400000;
    fail_count++;
    close_out;
  end
endmodule
